// ### hw/fdc_rate_write_shift_select_status_regs.v
// Floppy controller rate, precompensation, tape/media and main status registers.
// Notes on behaviour
// - Mode two media bits ignore every reset.
// - Bit 7 is media input one, optionally inverted.
// - Bit 6 is media input zero, optionally inverted.
// - Bits 5:4 pick drive type pair by drive.
// - Bits 3:2 mirror boot drive option bits.
// - Tape unit select stays read/write.
// - Hardware reset loads 02h; soft reset keeps.
// - Last of rate select or config wins.
// - Shift code sets write shift, halved at 2M.
// - Precompensation start track defaults to zero.
// - Default shift depends on data rate.
// - Low power until soft reset or access.
// - Bit 7 gives self-clearing controller reset.
// - Rate bits decode to rate and density.
// - Drive type maps rate onto density pins.
// - Status readable at any time, no wait.
// - Status holds request, direction, flags, seeks.
// - Request bit set only when transfer allowed.
// - Direction one asks host to read.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs_defs.vh"

module fdc_rate_write_shift_select_status_regs (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Media sense pins
    input wire [1:0] media_sense_input,
    // Command engine status
    input wire host_transfer_request,
    input wire transfer_direction,
    input wire polled_execution_flag,
    input wire command_in_progress,
    input wire [3:0] drive_seek_active,
    input wire data_reg_access,
    input wire write_shift_select_track_load,
    input wire [7:0] write_shift_select_track_value,
    // Controller control
    output reg controller_soft_reset,
    output reg clocks_stopped,
    output reg [7:0] write_shift_select_start_track,
    // Drive interface
    output reg [1:0] density_pins,
    output reg density_select,
    output reg [1:0] rate_out_bit,
    output reg [2:0] data_rate_code,
    output reg [15:0] write_shift_10ps,
    output reg [1:0] drive_select
);

    localparam integer SOFT_RESET_CYCLES =
        (`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [2:0] SOFT_RESET_CYC = SOFT_RESET_CYCLES[2:0];
    localparam [7:0] RATE_SELECT_INIT = `RATE_SELECT_RESET;

    // Software state.
    reg [2:0] shift_code_q;
    reg [1:0] rate_sel_q;
    reg [1:0] tape_sel_q;
    reg [7:0] drive_output_q;
    reg [7:0] drive_option_q;
    reg [7:0] drive_type_q;
    reg [1:0] fdc_mode_q;
    reg [1:0] drive_rate_table_q;
    reg no_write_shift_select_q;
    reg low_power_q;
    reg [2:0] reset_cnt_q;

    // Media sense synchronisers, deliberately without reset.
    reg [1:0] media_s1_q;
    reg [1:0] media_s2_q;
    reg [1:0] media_s3_q;
    reg [1:0] media_q;

    // Bus decode.
    wire [11:0] idx = paddr[13:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire access_done = psel & penable & pready;
    wire wr_en = access_done & pwrite & pstrb[0] & aligned & ~pslverr;
    wire rd_en = access_done & ~pwrite & aligned & ~pslverr;
    wire [7:0] wb = pwdata[7:0];

    wire wr_rate = wr_en & (idx == `IDX_RATE_STATUS);
    wire wr_config = wr_en & (idx == `IDX_RATE_CONFIG);
    wire wr_doc = wr_en & (idx == `IDX_DRIVE_OUTPUT);
    wire rd_status = rd_en & (idx == `IDX_RATE_STATUS);

    // The synchroniser output changes only when its last two stages agree.
    always @(posedge pclk) begin
        media_s1_q <= media_sense_input;
        media_s2_q <= media_s1_q;
        media_s3_q <= media_s2_q;
        if (media_s2_q[0] == media_s3_q[0]) begin
            media_q[0] <= media_s3_q[0];
        end
        if (media_s2_q[1] == media_s3_q[1]) begin
            media_q[1] <= media_s3_q[1];
        end
    end

    // Tape/media/boot register image.
    reg [1:0] type_pair;
    reg [7:0] tape_image;
    always @* begin
        case (drive_output_q[1:0])
            2'h0: type_pair = drive_type_q[1:0];
            2'h1: type_pair = drive_type_q[3:2];
            2'h2: type_pair = drive_type_q[5:4];
            default: type_pair = drive_type_q[7:6];
        endcase
        tape_image = {6'h00, tape_sel_q};
        if (fdc_mode_q == `MODE_ENH2) begin
            tape_image[7] = media_q[1] ^ drive_option_q[`OPT_INV1_BIT];
            tape_image[6] = media_q[0] ^ drive_option_q[`OPT_INV0_BIT];
            tape_image[5:4] = type_pair;
            tape_image[3] = drive_option_q[`OPT_BOOT_HI];
            tape_image[2] = drive_option_q[`OPT_BOOT_LO];
        end
    end

    wire [7:0] status_image = {host_transfer_request,
                               transfer_direction,
                               polled_execution_flag,
                               command_in_progress,
                               drive_seek_active};

    // Rate decode to rate code and density select.
    reg [2:0] rate_d;
    reg density_select_d;
    always @* begin
        case (rate_sel_q)
            `SEL_1M: begin
                rate_d = `RATE_1M;
                density_select_d = 1'b1;
            end
            `SEL_500K: begin
                rate_d = `RATE_500K;
                density_select_d = 1'b1;
            end
            `SEL_250K: begin
                rate_d = `RATE_250K;
                density_select_d = 1'b0;
            end
            default: begin
                density_select_d = 1'b0;
                case (drive_rate_table_q)
                    `DRT_THREE_MODE: rate_d = `RATE_500K;
                    `DRT_TAPE: rate_d = `RATE_2M;
                    default: rate_d = `RATE_300K;
                endcase
            end
        endcase
    end

    // Drive type pair steers what reaches the density pins.
    reg [1:0] pins_d;
    always @* begin
        case (type_pair)
            2'h0: pins_d = {rate_sel_q[0], density_select_d};
            2'h2: pins_d = {rate_sel_q[0], rate_sel_q[1]};
            2'h1: pins_d = {rate_sel_q[0], ~density_select_d};
            default: pins_d = {rate_sel_q[1], rate_sel_q[0]};
        endcase
    end

    wire [15:0] shift_d;
    write_shift_lookup u_shift (
        .shift_code(shift_code_q),
        .rate_code(rate_d),
        .shift_10ps(shift_d)
    );

    wire [31:0] state_image = {18'h00000, no_write_shift_select_q, shift_code_q, rate_sel_q,
                               density_select_d, pins_d, rate_d,
                               controller_soft_reset, low_power_q};

    // Read mux and address check.
    reg [31:0] rdata_d;
    reg err_d;
    always @* begin
        rdata_d = 32'h00000000;
        err_d = ~aligned;
        case (idx)
            `IDX_DRIVE_OUTPUT: rdata_d = {24'h000000, drive_output_q};
            `IDX_TAPE_MEDIA: rdata_d = {24'h000000, tape_image};
            // Reads here never touch the rate and shift bits, but they do end low power.
            `IDX_RATE_STATUS: rdata_d = {24'h000000, status_image};
            `IDX_RATE_CONFIG: err_d = ~aligned | ~pwrite;
            `IDX_DRIVE_OPTION: rdata_d = {24'h000000, drive_option_q};
            `IDX_DRIVE_TYPE: rdata_d = {24'h000000, drive_type_q};
            `IDX_FDC_MODE: rdata_d = {28'h0000000, drive_rate_table_q, fdc_mode_q};
            `IDX_BLOCK_STATE: begin
                rdata_d = state_image;
                err_d = ~aligned | pwrite;
            end
            default: err_d = 1'b1;
        endcase
        if (pwrite) begin
            rdata_d = 32'h00000000;
        end
    end

    // One wait-free access phase: ready is raised in the cycle after setup.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & err_d;
            if (psel & ~penable) begin
                prdata <= rdata_d;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Rate select, rate config and software registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_sel_q <= RATE_SELECT_INIT[1:0];
            shift_code_q <= RATE_SELECT_INIT[`RS_SHIFT_HI:`RS_SHIFT_LO];
            no_write_shift_select_q <= 1'b0;
            tape_sel_q <= 2'h0;
            drive_output_q <= `DRIVE_OUTPUT_RESET;
            drive_option_q <= 8'h00;
            drive_type_q <= 8'h00;
            fdc_mode_q <= `MODE_NORMAL;
            drive_rate_table_q <= `DRT_STANDARD;
            write_shift_select_start_track <= 8'h00;
        end else begin
            // Soft resets leave all of these alone.
            if (wr_rate) begin
                // Bit 5 is undefined and is not stored.
                rate_sel_q <= wb[1:0];
                shift_code_q <= wb[`RS_SHIFT_HI:`RS_SHIFT_LO];
            end else if (wr_config) begin
                rate_sel_q <= wb[1:0];
                no_write_shift_select_q <= wb[2];
            end
            if (wr_en & (idx == `IDX_TAPE_MEDIA)) begin
                tape_sel_q <= wb[1:0];
            end
            if (wr_doc) begin
                drive_output_q <= wb;
            end
            if (wr_en & (idx == `IDX_DRIVE_OPTION)) begin
                drive_option_q <= wb;
            end
            if (wr_en & (idx == `IDX_DRIVE_TYPE)) begin
                drive_type_q <= wb;
            end
            if (wr_en & (idx == `IDX_FDC_MODE)) begin
                fdc_mode_q <= wb[1:0];
                drive_rate_table_q <= wb[3:2];
            end
            if (write_shift_select_track_load) begin
                write_shift_select_start_track <= write_shift_select_track_value;
            end
        end
    end

    // Self-clearing reset pulse and manual low power.
    wire soft_reset_start = wr_rate & wb[`RS_RESET_BIT];
    wire doc_reset_low = ~drive_output_q[`DOC_RESET_N_BIT];
    wire reset_next = doc_reset_low | soft_reset_start | (reset_cnt_q != 3'h0);
    wire wake = controller_soft_reset | rd_status | data_reg_access;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_cnt_q <= 3'h0;
            low_power_q <= 1'b0;
            controller_soft_reset <= 1'b1;
            clocks_stopped <= 1'b0;
        end else begin
            if (soft_reset_start) begin
                reset_cnt_q <= SOFT_RESET_CYC;
            end else if (reset_cnt_q != 3'h0) begin
                reset_cnt_q <= reset_cnt_q - 3'h1;
            end
            controller_soft_reset <= reset_next;
            if (wr_rate & wb[`RS_LOW_POWER_BIT] & ~wb[`RS_RESET_BIT]) begin
                low_power_q <= 1'b1;
            end else if (wake | soft_reset_start) begin
                low_power_q <= 1'b0;
            end
            clocks_stopped <= low_power_q;
        end
    end

    // Registered drive interface outputs.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            density_pins <= 2'h0;
            density_select <= 1'b0;
            rate_out_bit <= 2'h2;
            data_rate_code <= `RATE_250K;
            write_shift_10ps <= `SHIFT_DEF_SLOW;
            drive_select <= 2'h0;
        end else begin
            density_pins <= pins_d;
            density_select <= density_select_d;
            rate_out_bit <= rate_sel_q;
            data_rate_code <= rate_d;
            write_shift_10ps <= shift_d;
            drive_select <= drive_output_q[1:0];
        end
    end

endmodule
`default_nettype wire

// ### hw/fdc_regs_defs.vh
// Constants for the floppy rate, precompensation and status register block.
`ifndef FDC_REGS_DEFS_VH
`define FDC_REGS_DEFS_VH

// Register indices; the byte address on APB is four times the index.
`define IDX_DRIVE_OUTPUT 12'h3f2
`define IDX_TAPE_MEDIA 12'h3f3
`define IDX_RATE_STATUS 12'h3f4
`define IDX_RATE_CONFIG 12'h3f7
`define IDX_DRIVE_OPTION 12'h3e0
`define IDX_DRIVE_TYPE 12'h3e1
`define IDX_FDC_MODE 12'h3e2
`define IDX_BLOCK_STATE 12'h3e3

// Reset values.
`define RATE_SELECT_RESET 8'h02
`define DRIVE_OUTPUT_RESET 8'h00
`define RATE_CONFIG_RESET 2'h2

// Rate select, drive output and drive option register fields.
`define RS_RESET_BIT 7
`define RS_LOW_POWER_BIT 6
`define RS_SHIFT_HI 4
`define RS_SHIFT_LO 2
`define DOC_RESET_N_BIT 2
`define OPT_BOOT_HI 7
`define OPT_BOOT_LO 6
`define OPT_INV1_BIT 5
`define OPT_INV0_BIT 4

// Floppy modes held in the mode register.
`define MODE_NORMAL 2'h0
`define MODE_ENH1 2'h1
`define MODE_ENH2 2'h2

// Data rate selections and resulting rate codes.
`define SEL_500K 2'h0
`define SEL_300K 2'h1
`define SEL_250K 2'h2
`define SEL_1M 2'h3
`define RATE_250K 3'h0
`define RATE_300K 3'h1
`define RATE_500K 3'h2
`define RATE_1M 3'h3
`define RATE_2M 3'h4
`define DRT_STANDARD 2'h0
`define DRT_THREE_MODE 2'h1
`define DRT_TAPE 2'h2

// Write shift delays in units of 10 ps.
`define SHIFT_CODE_DEFAULT 3'h0
`define SHIFT_CODE_NONE 3'h7
`define SHIFT_STEP_LOW 16'd4167
`define SHIFT_DEF_2M 16'd2080
`define SHIFT_DEF_1M 16'd4167
`define SHIFT_DEF_SLOW 16'd12500

// Timing.
`define CLK_PERIOD_NS 20
`define SOFT_RESET_NS 100

`endif

// ### hw/write_shift_lookup.v
// Write data shift lookup from shift code and data rate.
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs_defs.vh"

module write_shift_lookup (
    // Selection
    input wire [2:0] shift_code,
    input wire [2:0] rate_code,
    // Shift in units of 10 ps
    output reg [15:0] shift_10ps
);

    reg [15:0] full;

    always @* begin
        full = 16'h0000;
        shift_10ps = 16'h0000;
        // Steps of 41.67 ns; the odd hundredths follow the printed values.
        case (shift_code)
            3'h1: full = `SHIFT_STEP_LOW;
            3'h2: full = 16'd8334;
            3'h3: full = 16'd12500;
            3'h4: full = 16'd16667;
            3'h5: full = 16'd20833;
            3'h6: full = 16'd25000;
            default: full = 16'h0000;
        endcase
        if (shift_code == `SHIFT_CODE_DEFAULT) begin
            if (rate_code == `RATE_2M) begin
                shift_10ps = `SHIFT_DEF_2M;
            end else if (rate_code == `RATE_1M) begin
                shift_10ps = `SHIFT_DEF_1M;
            end else begin
                shift_10ps = `SHIFT_DEF_SLOW;
            end
        end else if (rate_code == `RATE_2M) begin
            // Halving truncates to 10 ps, within the printed rounding.
            shift_10ps = {1'b0, full[15:1]};
        end else begin
            shift_10ps = full;
        end
    end

endmodule
`default_nettype wire

// ### dv/fdc_regs_chk_sva.sv
// Assertion checker for the rate, precompensation and status register block.
`timescale 1ns/1ps
`default_nettype none
module fdc_regs_chk (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Command engine
    input wire logic host_transfer_request,
    input wire logic transfer_direction,
    input wire logic polled_execution_flag,
    input wire logic command_in_progress,
    input wire logic [3:0] drive_seek_active,
    input wire logic data_reg_access,
    input wire logic write_shift_select_track_load,
    input wire logic [7:0] write_shift_select_track_value,
    // Controller and drive side
    input wire logic controller_soft_reset,
    input wire logic clocks_stopped,
    input wire logic [7:0] write_shift_select_start_track,
    input wire logic density_select,
    input wire logic [1:0] rate_out_bit,
    input wire logic [2:0] data_rate_code
);
    logic [7:0] status_q;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Read data is latched at the setup edge, so the status is compared as it was then.
    always @(posedge pclk) begin
        status_q <= {host_transfer_request, transfer_direction, polled_execution_flag,
            command_in_progress, drive_seek_active};
    end
    sequence s_rate_wr;
        psel && penable && pready && pwrite && paddr == 14'hfd0 && pstrb[0];
    endsequence
    sequence s_status_rd;
        psel && penable && pready && !pwrite && paddr == 14'hfd0;
    endsequence
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready did not follow setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_status_fields: assert property (s_status_rd |-> prdata == {24'h0, status_q})
        else $error("status read data wrong");
    a_status_no_side: assert property (s_status_rd |=> $stable(data_rate_code))
        else $error("status read changed the rate");
    a_self_clear_reset: assert property (s_rate_wr ##0 pwdata[7]
        |=> controller_soft_reset [*5])
        else $error("reset pulse too short");
    a_low_power_entry: assert property (s_rate_wr ##0 pwdata[7:6] == 2'b01
        ##1 !data_reg_access |=> clocks_stopped) else $error("low power not entered");
    a_wake_on_data: assert property (clocks_stopped && data_reg_access && !(psel && pwrite)
        |-> ##2 !clocks_stopped) else $error("data access did not wake");
    a_rate_density: assert property (density_select ==
        (rate_out_bit == 2'h3 || rate_out_bit == 2'h0))
        else $error("density select does not match rate bits");
    a_rate_code: assert property (rate_out_bit != 2'h1 |-> data_rate_code ==
        (rate_out_bit == 2'h3 ? 3'h3 : rate_out_bit == 2'h0 ? 3'h2 : 3'h0))
        else $error("rate code does not match rate bits");
    a_track_load: assert property (write_shift_select_track_load |=>
        write_shift_select_start_track == $past(write_shift_select_track_value))
        else $error("start track not loaded");
    a_rate_at_reset: assert property ($rose(presetn) |->
        data_rate_code == 3'h0 && rate_out_bit == 2'h2)
        else $error("rate not 250K after reset");
endmodule
bind fdc_rate_write_shift_select_status_regs fdc_regs_chk u_fdc_regs_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .host_transfer_request, .transfer_direction,
    .polled_execution_flag, .command_in_progress, .drive_seek_active, .data_reg_access,
    .write_shift_select_track_load, .write_shift_select_track_value, .controller_soft_reset, .clocks_stopped,
    .write_shift_select_start_track, .density_select, .rate_out_bit, .data_rate_code);
`default_nettype wire

// ### dv/fdc_drive_model.sv
// Drive pins and command engine levels standing beside the register block.
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model (
    // Settings from the bench
    input wire logic [1:0] media_kind,
    input wire logic [7:0] status_set,
    // Drive and engine levels
    output logic [1:0] media_sense_input,
    output logic host_transfer_request,
    output logic transfer_direction,
    output logic polled_execution_flag,
    output logic command_in_progress,
    output logic [3:0] drive_seek_active
);
    // Media pins are slow static levels; the block synchronises them itself.
    assign media_sense_input = media_kind;
    assign {host_transfer_request, transfer_direction, polled_execution_flag,
        command_in_progress, drive_seek_active} = status_set;
endmodule
`default_nettype wire

// ### dv/fdc_rate_write_shift_select_status_regs_tb.sv
// Self-checking bench for the rate, precompensation and status register block.
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs_defs.vh"
module fdc_rate_write_shift_select_status_regs_tb;
    localparam logic [11:0] rsi = `IDX_RATE_STATUS;
    localparam logic [11:0] mdi = `IDX_FDC_MODE;
    localparam logic [11:0] doi = `IDX_DRIVE_OUTPUT;
    localparam logic [11:0] tpi = `IDX_TAPE_MEDIA;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, data_reg_access, err_q;
    logic write_shift_select_track_load, host_transfer_request, transfer_direction, polled_execution_flag;
    logic command_in_progress, controller_soft_reset, clocks_stopped, density_select;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [3:0] pstrb, drive_seek_active;
    logic [1:0] media_sense_input, media_kind, density_pins, rate_out_bit, drive_select;
    logic [7:0] write_shift_select_track_value, write_shift_select_start_track, status_set;
    logic [2:0] data_rate_code;
    logic [15:0] write_shift_10ps;
    int mismatches, checks_done;
    fdc_rate_write_shift_select_status_regs u_fdc_rate_write_shift_select_status_regs (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .media_sense_input,
        .host_transfer_request, .transfer_direction, .polled_execution_flag, .command_in_progress,
        .drive_seek_active, .data_reg_access, .write_shift_select_track_load, .write_shift_select_track_value,
        .controller_soft_reset, .clocks_stopped, .write_shift_select_start_track, .density_pins,
        .density_select, .rate_out_bit, .data_rate_code, .write_shift_10ps, .drive_select);
    fdc_drive_model u_fdc_drive_model (.media_kind, .status_set, .media_sense_input,
        .host_transfer_request, .transfer_direction, .polled_execution_flag,
        .command_in_progress, .drive_seek_active);
    task automatic finish_test();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_reset();
        chk(32'(data_rate_code), 32'(`RATE_250K));
        chk(32'(write_shift_10ps), 32'(`SHIFT_DEF_SLOW));
        chk(32'(write_shift_select_start_track), 32'h0);
        apb(0, `IDX_BLOCK_STATE, 8'h00);
        chk(rd_q, 32'h202);
        apb(0, 12'h000, 8'h00);
        chk(32'(err_q), 32'h1);
    endtask
    task automatic t_rates();
        logic [2:0] ec;
        for (int t = 0; t < 3; t++) begin
            for (int s = 0; s < 4; s++) begin
                apb(1, mdi, 8'(t * 4 + 2));
                apb(1, rsi, 8'(s));
                wt(3);
                ec = s == 3 ? `RATE_1M : s == 0 ? `RATE_500K : s == 2 ? `RATE_250K :
                    t == 0 ? `RATE_300K : t == 1 ? `RATE_500K : `RATE_2M;
                chk(32'(data_rate_code), 32'(ec));
                chk(32'(density_select), 32'(s == 0 || s == 3));
                chk(32'(rate_out_bit), 32'(s));
            end
        end
        apb(1, rsi, 8'h03);
        apb(1, `IDX_RATE_CONFIG, 8'h02);
        wt(3);
        chk(32'(data_rate_code), 32'(`RATE_250K));
        apb(1, rsi, 8'h00);
        apb(0, rsi, 8'h00);
        wt(3);
        chk(32'(data_rate_code), 32'(`RATE_500K));
    endtask
    task automatic t_shift();
        int lo[8] = '{12500, 4167, 8334, 12500, 16667, 20833, 25000, 0};
        for (int c = 0; c < 8; c++) begin
            apb(1, mdi, 8'h02);
            apb(1, rsi, 8'(c * 4 + 2));
            wt(3);
            chk(32'(write_shift_10ps), 32'(lo[c]));
            apb(1, mdi, 8'h0a);
            apb(1, rsi, 8'(c * 4 + 1));
            wt(3);
            chk(32'(write_shift_10ps), c == 0 ? 32'(`SHIFT_DEF_2M) : 32'(lo[c] / 2));
        end
        apb(1, rsi, 8'h03);
        wt(3);
        chk(32'(write_shift_10ps), 32'(`SHIFT_DEF_1M));
    endtask
    // Two rates are used because a single one leaves some density mappings alike.
    task automatic t_drive();
        logic [1:0] e;
        apb(1, `IDX_DRIVE_TYPE, 8'he4);
        for (int s = 0; s < 2; s++) begin
            apb(1, rsi, 8'(s));
            for (int d = 0; d < 4; d++) begin
                apb(1, doi, 8'(4 + d));
                apb(0, tpi, 8'h00);
                chk(32'(rd_q[5:4]), 32'(d));
                e = d == 0 ? {s[0], ~s[0]} : d == 1 ? {s[0], s[0]} :
                    d == 2 ? {s[0], 1'b0} : {1'b0, s[0]};
                wt(2);
                chk(32'(density_pins), 32'(e));
                chk(32'(drive_select), 32'(d));
            end
        end
    endtask
    task automatic t_media();
        apb(1, doi, 8'h04);
        apb(1, `IDX_DRIVE_OPTION, 8'hf0);
        apb(1, tpi, 8'h01);
        apb(0, tpi, 8'h00);
        chk(rd_q, 32'h4d);
        apb(1, `IDX_DRIVE_OPTION, 8'h00);
        apb(0, tpi, 8'h00);
        chk(rd_q, 32'h81);
        apb(1, mdi, 8'h00);
        apb(0, tpi, 8'h00);
        chk(rd_q, 32'h01);
    endtask
    task automatic t_power();
        apb(1, rsi, 8'h42);
        wt(2);
        chk(32'(clocks_stopped), 32'h1);
        @(posedge pclk);
        data_reg_access <= 1'b1;
        @(posedge pclk);
        data_reg_access <= 1'b0;
        wt(3);
        chk(32'(clocks_stopped), 32'h0);
        apb(1, rsi, 8'h42);
        apb(0, rsi, 8'h00);
        wt(2);
        chk(32'(clocks_stopped), 32'h0);
        apb(1, rsi, 8'h42);
        apb(1, doi, 8'h00);
        apb(1, doi, 8'h04);
        wt(3);
        chk(32'(clocks_stopped), 32'h0);
        chk(32'(data_rate_code), 32'(`RATE_250K));
        apb(1, rsi, 8'h81);
        wt(2);
        chk(32'(controller_soft_reset), 32'h1);
        wt(10);
        chk(32'(controller_soft_reset), 32'h0);
        chk(32'(data_rate_code), 32'(`RATE_300K));
    endtask
    task automatic t_status();
        status_set <= 8'hd5;
        apb(1, rsi, 8'h02);
        apb(0, rsi, 8'h00);
        chk(rd_q, 32'hd5);
        status_set <= 8'h2a;
        apb(0, rsi, 8'h00);
        chk(rd_q, 32'h2a);
        chk(32'(data_rate_code), 32'(`RATE_250K));
        write_shift_select_track_value <= 8'h05;
        write_shift_select_track_load <= 1'b1;
        @(posedge pclk);
        write_shift_select_track_load <= 1'b0;
        wt(2);
        chk(32'(write_shift_select_start_track), 32'h5);
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        finish_test();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, data_reg_access, write_shift_select_track_load} = '0;
        {paddr, pwdata, write_shift_select_track_value, status_set} = '0;
        pstrb = 4'hf;
        media_kind = 2'b10;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rates();
        t_shift();
        t_drive();
        t_media();
        t_power();
        t_status();
        finish_test();
    end
endmodule
`default_nettype wire
